// ==== common/smcb_pkg.sv ====
package smcb_pkg;
  localparam int SMCB_PORTS = 5;

  // Serial configuration memory byte addresses and signature byte values
  localparam logic [7:0] SMCB_ROM_SIG0 = 8'h00;
  localparam logic [7:0] SMCB_ROM_SIG1 = 8'h01;
  localparam logic [7:0] SMCB_REG_CTRL3 = 8'h06;
  localparam logic [7:0] SMCB_REG_RSV7 = 8'h07;
  localparam logic [7:0] SMCB_REG_TRX1 = 8'h08;
  localparam logic [7:0] SMCB_REG_TRX2 = 8'h09;
  localparam logic [7:0] SMCB_REG_VER1 = 8'h0A;
  localparam logic [7:0] SMCB_REG_VER2 = 8'h0B;
  localparam logic [7:0] SMCB_SIG_FIRST = 8'h55;
  localparam logic [7:0] SMCB_SIG_SECOND = 8'hAA;

  // Field positions
  localparam int SMCB_BIT_KEEP = 7;
  localparam int SMCB_BIT_AGING = 4;
  localparam int SMCB_BIT_IDLE = 2;
  localparam int SMCB_BIT_MODBCK = 1;
  localparam int SMCB_BIT_PWRSAVE = 1;
  localparam int SMCB_BIT_MDIX = 0;

  // Values after reset and writable masks
  localparam logic [7:0] SMCB_CTRL3_RST = 8'h92;
  localparam logic [7:0] SMCB_CTRL3_MASK = 8'hF6;
  localparam logic [7:0] SMCB_TRX2_RST = 8'h03;
  localparam logic [7:0] SMCB_TRX2_MASK = 8'h03;
  localparam logic [7:0] SMCB_VER2_RST = 8'h00;
  localparam logic [7:0] SMCB_VER2_MASK = 8'h10;

  // Counts and times
  localparam logic [4:0] SMCB_COLL_LIMIT = 5'h10;
  localparam logic [8:0] SMCB_AGE_LIMIT_S = 9'h12C;
  localparam logic [3:0] SMCB_BACKOFF_CAP_EXP = 4'h4;
  localparam logic [3:0] SMCB_BACKOFF_STD_EXP = 4'hA;
  localparam int SMCB_CLK_NS = 10;
  localparam int SMCB_WAKE_NS = 100;
  localparam int SMCB_WAKE_CYCLES = (SMCB_WAKE_NS + SMCB_CLK_NS - 1)
                                    / SMCB_CLK_NS;
  localparam int SMCB_WAKE_W = 4;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
    logic done;
  } smcb_rom_t;

  typedef struct packed {
    logic valid;
    logic [8:0] seconds;
  } smcb_age_t;

  typedef struct packed {
    logic [SMCB_PORTS-1:0] collision;
    logic [SMCB_PORTS-1:0] tx_done;
    logic [SMCB_PORTS-1:0] backing_off;
    logic [SMCB_PORTS-1:0] flp_req;
    logic [SMCB_PORTS-1:0][3:0] backoff_k;
  } smcb_port_in_t;

  typedef struct packed {
    logic [SMCB_PORTS-1:0] drop_frame;
    logic [SMCB_PORTS-1:0] keep_frame;
    logic [SMCB_PORTS-1:0] idle_check;
    logic [SMCB_PORTS-1:0] wake;
    logic [SMCB_PORTS-1:0] flp_go;
    logic [SMCB_PORTS-1:0] auto_mdix;
    logic [SMCB_PORTS-1:0][3:0] backoff_exp;
  } smcb_port_out_t;

  typedef struct packed {
    logic loaded;
    logic sig_ok;
    logic [7:0] sig0;
    logic [7:0] sig1;
    logic [7:0] stage6;
    logic [7:0] stage9;
    logic [7:0] stageb;
    logic [7:0] cfg6;
    logic [7:0] cfg9;
    logic [7:0] cfgb;
    logic [7:0] rd_data;
    logic age_expire;
    smcb_port_out_t po;
    logic [SMCB_PORTS-1:0][4:0] coll_cnt;
    logic [SMCB_PORTS-1:0][SMCB_WAKE_W-1:0] wake_cnt;
  } smcb_state_t;
endpackage : smcb_pkg

// ==== rtl/smcb_config_bits.sv ====
module smcb_config_bits (
  input wire logic clk,
  input wire logic arst_n,
  input wire smcb_pkg::smcb_rom_t rom,
  input wire logic [7:0] rd_addr,
  input wire smcb_pkg::smcb_age_t age_q,
  input wire smcb_pkg::smcb_port_in_t pin,
  output smcb_pkg::smcb_port_out_t pout,
  output logic [7:0] rd_data,
  output logic age_expire,
  output logic config_loaded,
  output logic signature_ok
);
  import smcb_pkg::*;

  if (SMCB_WAKE_CYCLES < 2 || SMCB_WAKE_CYCLES > 15) begin : g_chk
    $error("wake lead time out of range");
  end

  smcb_state_t s;
  smcb_state_t next_s;

  function automatic logic [7:0] apply_mask(input logic [7:0] raw,
                                            input logic [7:0] mask,
                                            input logic [7:0] rst);
    apply_mask = (raw & mask) | (rst & ~mask);
  endfunction : apply_mask

  logic keep_bit;
  logic aging_bit;
  logic idle_bit;
  logic modbck_bit;
  logic pwrsave_bit;
  logic mdix_bit;
  assign keep_bit = s.cfg6[SMCB_BIT_KEEP];
  assign aging_bit = s.cfg6[SMCB_BIT_AGING];
  assign idle_bit = s.cfg6[SMCB_BIT_IDLE];
  assign modbck_bit = s.cfg6[SMCB_BIT_MODBCK];
  assign pwrsave_bit = s.cfg9[SMCB_BIT_PWRSAVE];
  assign mdix_bit = s.cfg9[SMCB_BIT_MDIX];

  always_comb begin
    logic [3:0] cap;
    cap = '0;
    next_s = s;
    // Configuration load, open only until the first done after reset
    if (!s.loaded && rom.valid) begin
      unique case (rom.addr)
        SMCB_ROM_SIG0: next_s.sig0 = rom.data;
        SMCB_ROM_SIG1: next_s.sig1 = rom.data;
        SMCB_REG_CTRL3: next_s.stage6 = rom.data;
        SMCB_REG_TRX2: next_s.stage9 = rom.data;
        SMCB_REG_VER2: next_s.stageb = rom.data;
        default: next_s.sig0 = s.sig0;
      endcase
    end
    if (!s.loaded && rom.done) begin
      next_s.loaded = 1'b1;
      if (s.sig0 == SMCB_SIG_FIRST && s.sig1 == SMCB_SIG_SECOND) begin
        next_s.sig_ok = 1'b1;
        next_s.cfg6 = apply_mask(s.stage6, SMCB_CTRL3_MASK,
                                 SMCB_CTRL3_RST);
        next_s.cfg9 = apply_mask(s.stage9, SMCB_TRX2_MASK,
                                 SMCB_TRX2_RST);
        next_s.cfgb = apply_mask(s.stageb, SMCB_VER2_MASK,
                                 SMCB_VER2_RST);
      end
    end
    // Management readback of the mirrored bytes
    unique case (rd_addr)
      SMCB_REG_CTRL3: next_s.rd_data = s.cfg6;
      SMCB_REG_TRX2: next_s.rd_data = s.cfg9;
      SMCB_REG_VER2: next_s.rd_data = s.cfgb;
      default: next_s.rd_data = 8'h00;
    endcase
    // Address aging decision
    next_s.age_expire = age_q.valid && aging_bit
                        && age_q.seconds >= SMCB_AGE_LIMIT_S;
    // Per-port behaviour, same settings on every port
    for (int i = 0; i < SMCB_PORTS; i++) begin
      next_s.po.drop_frame[i] = 1'b0;
      next_s.po.keep_frame[i] = 1'b0;
      next_s.po.flp_go[i] = 1'b0;
      if (pin.tx_done[i]) begin
        next_s.coll_cnt[i] = 5'h00;
      end else if (pin.collision[i]) begin
        if (s.coll_cnt[i] == SMCB_COLL_LIMIT - 5'h01) begin
          next_s.coll_cnt[i] = 5'h00;
          next_s.po.keep_frame[i] = keep_bit;
          next_s.po.drop_frame[i] = !keep_bit;
        end else begin
          next_s.coll_cnt[i] = s.coll_cnt[i] + 5'h01;
        end
      end
      next_s.po.idle_check[i] = idle_bit && pin.backing_off[i];
      cap = modbck_bit ? SMCB_BACKOFF_CAP_EXP
                       : SMCB_BACKOFF_STD_EXP;
      next_s.po.backoff_exp[i] = (pin.backoff_k[i] > cap) ? cap
                                 : pin.backoff_k[i];
      next_s.po.auto_mdix[i] = mdix_bit;
      if (s.po.wake[i]) begin
        next_s.wake_cnt[i] = s.wake_cnt[i] - 4'h1;
        if (s.wake_cnt[i] == 4'h1) begin
          next_s.po.wake[i] = 1'b0;
          next_s.po.flp_go[i] = 1'b1;
        end
      end else if (pin.flp_req[i]) begin
        if (pwrsave_bit) begin
          next_s.po.wake[i] = 1'b1;
          next_s.wake_cnt[i] = 4'(SMCB_WAKE_CYCLES);
        end else begin
          next_s.po.flp_go[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.cfg6 <= SMCB_CTRL3_RST;
      s.cfg9 <= SMCB_TRX2_RST;
      s.cfgb <= SMCB_VER2_RST;
      s.po.auto_mdix <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign pout = s.po;
  assign rd_data = s.rd_data;
  assign age_expire = s.age_expire;
  assign config_loaded = s.loaded;
  assign signature_ok = s.sig_ok;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_age_expire: assert property (age_q.valid && aging_bit
    && age_q.seconds >= SMCB_AGE_LIMIT_S |=> age_expire)
    else $error("aging entry not expired");
  a_age_never: assert property (!aging_bit |=> !age_expire)
    else $error("entry aged while aging off");
  a_sig_bad: assert property (!s.loaded && rom.done
    && s.sig0 != SMCB_SIG_FIRST |=> s.cfg6 == $past(s.cfg6)
    && !signature_ok)
    else $error("config applied without signature");
  a_sig_good: assert property (!s.loaded && rom.done
    && s.sig0 == SMCB_SIG_FIRST && s.sig1 == SMCB_SIG_SECOND
    |=> signature_ok && config_loaded)
    else $error("signature seen but config not applied");
  a_load_once: assert property (s.loaded |=> s.loaded
    && $stable(s.cfg6) && $stable(s.cfg9))
    else $error("config changed after load");
  a_rsvd_hold: assert property ((s.cfg6 & ~SMCB_CTRL3_MASK)
    == (SMCB_CTRL3_RST & ~SMCB_CTRL3_MASK)
    && (s.cfg9 & ~SMCB_TRX2_MASK) == 8'h00)
    else $error("reserved bit moved off its default");

  for (genvar gi = 0; gi < SMCB_PORTS; gi++) begin : g_port
    sequence s_limit_hit;
      pin.collision[gi] && !pin.tx_done[gi]
        && s.coll_cnt[gi] == SMCB_COLL_LIMIT - 5'h01;
    endsequence
    sequence s_slow_req;
      pin.flp_req[gi] && !pout.wake[gi] && pwrsave_bit;
    endsequence
    sequence s_fast_req;
      pin.flp_req[gi] && !pout.wake[gi] && !pwrsave_bit;
    endsequence
    a_drop_limit: assert property (s_limit_hit |=>
      pout.drop_frame[gi] == !$past(keep_bit)
      && pout.keep_frame[gi] == $past(keep_bit))
      else $error("retry limit outcome wrong");
    a_count_clear: assert property (pin.tx_done[gi] |=>
      s.coll_cnt[gi] == 5'h00 && !pout.drop_frame[gi]
      && !pout.keep_frame[gi])
      else $error("collision count not cleared by tx done");
    a_idle_on: assert property (idle_bit && pin.backing_off[gi] |=>
      pout.idle_check[gi])
      else $error("idle check missing during backoff");
    a_idle_only: assert property (pout.idle_check[gi] |->
      $past(pin.backing_off[gi]) && $past(idle_bit))
      else $error("idle check outside backoff");
    a_backoff_cap: assert property (modbck_bit |=>
      pout.backoff_exp[gi] <= SMCB_BACKOFF_CAP_EXP)
      else $error("backoff exceeds cap");
    a_wake_lead: assert property (s_slow_req |=>
      pout.wake[gi] && !pout.flp_go[gi] ##1 pout.wake[gi])
      else $error("no wake before pulses");
    a_flp_after: assert property (pout.flp_go[gi] && $past(pwrsave_bit)
      && $past(pout.wake[gi]) |-> !pout.wake[gi])
      else $error("pulses overlap wake");
    a_no_wake: assert property (s_fast_req |=>
      pout.flp_go[gi] && !pout.wake[gi])
      else $error("wake while power-save off");
    a_mdix_follow: assert property (##1 pout.auto_mdix[gi]
      == $past(mdix_bit))
      else $error("crossover enable not followed");
  end
endmodule : smcb_config_bits

// ==== sim/smcb_config_bits_tb.sv ====
module smcb_config_bits_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smcb_pkg::*;

  logic clk, arst_n, start, sig_good, age_expire, config_loaded;
  logic signature_ok;
  logic [7:0] b6, b9, rd_addr, rd_data;
  smcb_rom_t rom;
  smcb_age_t age_q;
  smcb_port_in_t pin;
  smcb_port_out_t pout;
  int n_mismatch = 0;
  int comparisons = 0;

  smcb_config_bits dut (.clk(clk), .arst_n(arst_n), .rom(rom),
    .rd_addr(rd_addr), .age_q(age_q), .pin(pin), .pout(pout),
    .rd_data(rd_data), .age_expire(age_expire),
    .config_loaded(config_loaded), .signature_ok(signature_ok));

  smcb_rom_model mem (.clk(clk), .start(start), .sig_good(sig_good),
    .b6(b6), .b9(b9), .rom(rom));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic rst();
    arst_n = 1'b0;
    repeat (3) step();
    arst_n = 1'b1;
  endtask : rst

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_addr = a;
    step();
    chk("rd_data", rd_data, e);
  endtask : rd

  task automatic load(input logic g, input logic [7:0] v6, v9);
    int n;
    sig_good = g;
    b6 = v6;
    b9 = v9;
    start = 1'b1;
    step();
    start = 1'b0;
    n = 0;
    while (config_loaded !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    if (n == 40) begin
      n_mismatch++;
      finish_test();
    end
    chk("sig_ok", signature_ok, g);
  endtask : load

  task automatic ops(input logic kp, cap, ag, idl, pw);
    int n;
    pin.collision = '1;
    repeat (8) step();
    pin.tx_done = '1;
    step();
    pin.tx_done = '0;
    repeat (15) step();
    chk("early", pout.keep_frame | pout.drop_frame, 5'h00);
    step();
    pin.collision = '0;
    chk("keep", pout.keep_frame, kp ? 5'h1F : 5'h00);
    chk("drop", pout.drop_frame, kp ? 5'h00 : 5'h1F);
    pin.backoff_k = {5{4'h9}};
    step();
    chk("bexp", pout.backoff_exp, cap ? {5{4'h4}} : {5{4'h9}});
    age_q = '{1'b1, 9'h12C};
    step();
    chk("age300", age_expire, ag);
    age_q.seconds = 9'h12B;
    step();
    chk("age299", age_expire, 1'b0);
    age_q.valid = 1'b0;
    pin.backing_off = '1;
    step();
    chk("idle", pout.idle_check, idl ? 5'h1F : 5'h00);
    pin.backing_off = '0;
    step();
    chk("idle_off", pout.idle_check, 5'h00);
    chk("mdix", pout.auto_mdix, 5'h1F);
    pin.flp_req = '1;
    step();
    pin.flp_req = '0;
    chk("wake", pout.wake, pw ? 5'h1F : 5'h00);
    n = 0;
    while (pout.wake !== 5'h00 && n < 20) begin
      step();
      n++;
    end
    chk("wake_len", 32'(n), pw ? 32'hA : 32'h0);
    chk("flp_go", pout.flp_go, 5'h1F);
    step();
  endtask : ops

  initial begin
    arst_n = 1'b0;
    start = 1'b0;
    sig_good = 1'b1;
    b6 = 8'h00;
    b9 = 8'h00;
    rd_addr = 8'h00;
    age_q = '0;
    pin = '0;
    rst();
    rd(SMCB_REG_CTRL3, 8'h92);
    rd(SMCB_REG_TRX2, 8'h03);
    rd(SMCB_REG_VER2, 8'h00);
    ops(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    rst();
    load(1'b0, 8'h0D, 8'hFD);
    rd(SMCB_REG_CTRL3, 8'h92);
    rst();
    load(1'b1, 8'h0D, 8'hFD);
    rd(SMCB_REG_CTRL3, 8'h04);
    rd(SMCB_REG_TRX2, 8'h01);
    rd(SMCB_REG_VER2, 8'h10);
    rd(SMCB_REG_RSV7, 8'h00);
    ops(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    finish_test();
  end
endmodule : smcb_config_bits_tb

// ==== sim/smcb_rom_model.sv ====
module smcb_rom_model (
  input wire logic clk,
  input wire logic start,
  input wire logic sig_good,
  input wire logic [7:0] b6,
  input wire logic [7:0] b9,
  output smcb_pkg::smcb_rom_t rom
);
  timeunit 1ns;
  timeprecision 1ns;
  import smcb_pkg::*;

  initial begin
    rom = '0;
  end

  task automatic send(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    rom.valid = 1'b1;
    rom.addr = a;
    rom.data = d;
  endtask : send

  // Streams one image, then releases the bus with inverted lines
  always @(posedge start) begin
    send(SMCB_ROM_SIG0, sig_good ? 8'h55 : 8'h54);
    send(SMCB_ROM_SIG1, 8'hAA);
    send(SMCB_REG_CTRL3, b6);
    send(SMCB_REG_TRX2, b9);
    send(SMCB_REG_VER2, 8'h10);
    send(SMCB_REG_RSV7, 8'hFF);
    @(posedge clk);
    #1;
    rom.valid = 1'b0;
    rom.addr = ~rom.addr;
    rom.data = ~rom.data;
    rom.done = 1'b1;
    @(posedge clk);
    #1;
    rom.done = 1'b0;
  end
endmodule : smcb_rom_model
